// ===== tspfm_pid_match.sv
`timescale 1ns/100ps
`default_nettype none
module tspfm_pid_match (
    // one filter entry
    input  wire tspfm_pkg::tspfm_ent_t i_ent,
    // packet fields
    input  wire logic [12:0]           i_pid,
    input  wire logic [7:0]            i_stype,
    // compare results
    output logic                       o_pid_hit,
    output logic                       o_type_hit
);

    assign o_pid_hit  = i_ent.valid && (i_ent.pid == i_pid);
    assign o_type_hit = i_ent.valid && (i_ent.stype == i_stype);

endmodule
`default_nettype wire

// ===== tspfm_pkg.sv
`default_nettype none
package tspfm_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_FILT = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_BPID = 8'h10;
    localparam logic [7:0] OFS_PMTP = 8'h14;
    localparam logic [7:0] OFS_BASE = 8'h18;
    localparam logic [7:0] OFS_ENT0 = 8'h20;

    // field positions
    localparam int BIT_RSM  = 0;
    localparam int IRQ_BND  = 0;
    localparam int IRQ_PAT  = 1;
    localparam int IRQ_PMT  = 2;
    localparam int IRQ_W    = 3;
    localparam int FILT_W   = 5;
    localparam int PID_W    = 13;
    localparam int IDX_W    = 3;
    localparam int NUM_FILT = 6;

    // reset values and fixed identifiers
    localparam logic [PID_W-1:0] PAT_PID  = 13'h0000;
    localparam logic [PID_W-1:0] PMTP_RST = 13'h1FFF;
    localparam logic [31:0]      WORD_RST = 32'h00000000;
    localparam logic [31:0]      ADDR_INC = 32'h00000004;

    typedef enum logic [2:0] {
        MODE_MANUAL = 3'h0,
        MODE_SEMI_A = 3'h1,
        MODE_SEMI_B = 3'h2,
        MODE_FULL   = 3'h3
    } tspfm_mode_t;

    // gray sequence idle -> pat -> pmt -> run
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PAT  = 2'b01,
        ST_PMT  = 2'b11,
        ST_RUN  = 2'b10
    } tspfm_state_t;

    typedef struct packed {
        logic       bsel;
        logic       fen;
        logic [2:0] mode;
    } tspfm_filt_t;

    typedef struct packed {
        logic             valid;
        logic [6:0]       rsv_hi;
        logic [7:0]       stype;
        logic [2:0]       rsv_lo;
        logic [PID_W-1:0] pid;
    } tspfm_ent_t;

    typedef struct packed {
        logic [PID_W-1:0] pid;
        logic             discontinuity_info_table;
        logic [PID_W-1:0] tbl_pid;
        logic [7:0]       tbl_type;
    } tspfm_pkt_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } tspfm_store_t;

endpackage
`default_nettype wire

// ===== tspfm_src.sv
`timescale 1ns/100ps
`default_nettype none
module tspfm_src (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    // request from the bench
    input  wire logic                  i_go,
    input  wire logic [1:0]            i_delay,
    input  wire tspfm_pkg::tspfm_pkt_t i_desc,
    // descriptor toward the receiver
    output logic                       o_valid,
    output tspfm_pkg::tspfm_pkt_t      o_pkt
);
    tspfm_pkg::tspfm_pkt_t desc_reg;
    logic [1:0]            cnt_reg;
    logic                  busy_reg;

    // fields carry fresh junk outside a valid cycle so nothing leans on them
    always_ff @(posedge i_clk) begin
        o_valid <= 1'b0;
        o_pkt   <= 35'({$urandom, $urandom});
        if (i_reset) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 2'h0;
        end else if (i_go) begin
            busy_reg <= 1'b1;
            desc_reg <= i_desc;
            cnt_reg  <= i_delay;
        end else if (busy_reg && cnt_reg == 2'h0) begin
            busy_reg <= 1'b0;
            o_valid  <= 1'b1;
            o_pkt    <= desc_reg;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tspfm_top.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - boundary select 0 uses discontinuity table packets
// - boundary select 1 uses programmed boundary PID
// - boundary select ignored unless filter enabled
// - filter enable needs receive stream mode set
// - filter disabled means bypass, all packets pass
// - interrupt mask writes leave filter control intact
// - mode codes 0-3 defined, 4-7 reserved
// - manual mode never decodes tables
// - mode A stores decoded PAT to memory
// - mode A interrupts on every new PAT
// - mode A stores PMT and interrupts
// - mode A boundary interrupts, returns to PAT
// - mode B parses once both enables set
// - mode B updates tables on PMT change
// - table entries matched and replaced by type
// - full mode decodes tables internally, then B
module tspfm_top #(
    parameter int NUM_FILT = tspfm_pkg::NUM_FILT
) (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    // register port
    input  wire logic [7:0]             i_addr,
    input  wire logic [31:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [31:0]            o_rdata,
    // incoming packet descriptors
    input  wire logic                   i_pkt_valid,
    input  wire tspfm_pkg::tspfm_pkt_t  i_pkt,
    // forwarded packets
    output logic                        o_pkt_valid,
    output logic      [12:0]            o_pkt_pid,
    // table store toward memory
    output logic                        o_store_valid,
    output tspfm_pkg::tspfm_store_t     o_store,
    // interrupt
    output logic                        o_irq
);

    logic                              rsm_reg;
    tspfm_pkg::tspfm_filt_t            filt_reg;
    logic [tspfm_pkg::IRQ_W-1:0]       stat_reg;
    logic [tspfm_pkg::IRQ_W-1:0]       mask_reg;
    logic [12:0]                       bpid_reg;
    logic [12:0]                       pmtp_reg;
    logic [31:0]                       base_reg;
    logic [31:0]                       off_reg;
    tspfm_pkg::tspfm_ent_t             ent_reg [NUM_FILT];
    tspfm_pkg::tspfm_state_t           state_reg;
    tspfm_pkg::tspfm_state_t           state_next;
    logic [tspfm_pkg::IRQ_W-1:0]       ev;
    logic [NUM_FILT-1:0]               pid_hit;
    logic [NUM_FILT-1:0]               type_hit;
    logic [7:0]                        ent_off;
    logic                              wr_ent;
    logic [tspfm_pkg::IDX_W-1:0]       wr_idx;
    logic [tspfm_pkg::IDX_W-1:0]       upd_idx;
    logic                              upd_ok;
    logic                              upd;
    tspfm_pkg::tspfm_ent_t             ent_wr;
    logic                              act;
    logic                              mode_a;
    logic                              mode_b;
    logic                              mode_f;
    logic                              decode;
    logic                              pat_hit;
    logic                              pmt_hit;
    logic                              bnd_hit;
    logic                              store_ev;
    logic [31:0]                       rdata_next;

    // filter logic only counts when the receiver is in stream mode
    assign act    = rsm_reg && filt_reg.fen;

    // reserved codes fall back to manual behaviour
    assign mode_a = filt_reg.mode == tspfm_pkg::MODE_SEMI_A;
    assign mode_b = filt_reg.mode == tspfm_pkg::MODE_SEMI_B;
    assign mode_f = filt_reg.mode == tspfm_pkg::MODE_FULL;
    assign decode = act && (mode_a || mode_b || mode_f);

    assign pat_hit = decode && i_pkt_valid
                     && i_pkt.pid == tspfm_pkg::PAT_PID;
    assign pmt_hit = decode && i_pkt_valid && i_pkt.pid == pmtp_reg;

    // select only meaningful while filtering is active
    always_comb begin
        bnd_hit = 1'b0;
        if (act && i_pkt_valid) begin
            if (filt_reg.bsel) begin
                bnd_hit = i_pkt.pid == bpid_reg;
            end else begin
                bnd_hit = i_pkt.discontinuity_info_table;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_FILT; g++) begin : g_cmp
            tspfm_pid_match u_match (
                .i_ent      (ent_reg[g]),
                .i_pid      (i_pkt.pid),
                .i_stype    (i_pkt.tbl_type),
                .o_pid_hit  (pid_hit[g]),
                .o_type_hit (type_hit[g])
            );
        end
    endgenerate

    // a same type entry wins over a free slot
    always_comb begin
        upd_idx = '0;
        upd_ok  = 1'b0;
        for (int k = NUM_FILT - 1; k >= 0; k--) begin
            if (!ent_reg[k].valid) begin
                upd_idx = tspfm_pkg::IDX_W'(k);
                upd_ok  = 1'b1;
            end
        end
        for (int k = NUM_FILT - 1; k >= 0; k--) begin
            if (type_hit[k]) begin
                upd_idx = tspfm_pkg::IDX_W'(k);
                upd_ok  = 1'b1;
            end
        end
    end

    assign upd = pmt_hit && upd_ok
                 && ((state_reg == tspfm_pkg::ST_RUN
                      && (mode_b || mode_f))
                     || (state_reg == tspfm_pkg::ST_PMT
                         && mode_f));

    assign ent_off = i_addr - tspfm_pkg::OFS_ENT0;
    assign wr_ent  = i_addr >= tspfm_pkg::OFS_ENT0
                     && ent_off[1:0] == 2'h0
                     && 32'(ent_off[7:2]) < NUM_FILT;
    assign wr_idx  = ent_off[tspfm_pkg::IDX_W+1:2];

    always_comb begin
        ent_wr        = i_wdata;
        ent_wr.rsv_hi = '0;
        ent_wr.rsv_lo = '0;
    end

    // mode sequencer
    always_comb begin
        state_next = state_reg;
        if (!decode) begin
            state_next = tspfm_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                tspfm_pkg::ST_IDLE: begin
                    if (mode_b) begin
                        state_next = tspfm_pkg::ST_RUN;
                    end else begin
                        state_next = tspfm_pkg::ST_PAT;
                    end
                end
                tspfm_pkg::ST_PAT: begin
                    if (pat_hit) begin
                        state_next = tspfm_pkg::ST_PMT;
                    end
                end
                tspfm_pkg::ST_PMT: begin
                    if (pmt_hit) begin
                        state_next = tspfm_pkg::ST_RUN;
                    end
                end
                tspfm_pkg::ST_RUN: begin
                    if (mode_a && bnd_hit) begin
                        state_next = tspfm_pkg::ST_PAT;
                    end
                end
                default: state_next = tspfm_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= tspfm_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // control registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rsm_reg  <= 1'b0;
            filt_reg <= '0;
            mask_reg <= '0;
            bpid_reg <= '0;
            base_reg <= tspfm_pkg::WORD_RST;
        end else if (i_wr) begin
            case (i_addr)
                tspfm_pkg::OFS_MAIN:
                    rsm_reg <= i_wdata[tspfm_pkg::BIT_RSM];
                tspfm_pkg::OFS_FILT:
                    filt_reg <= i_wdata[tspfm_pkg::FILT_W-1:0];
                // mask has its own word so filter control survives
                tspfm_pkg::OFS_MASK:
                    mask_reg <= i_wdata[tspfm_pkg::IRQ_W-1:0];
                tspfm_pkg::OFS_BPID:
                    bpid_reg <= i_wdata[12:0];
                tspfm_pkg::OFS_BASE:
                    base_reg <= i_wdata;
                default: ;
            endcase
        end
    end

    // program map PID: host in modes A and B, decoded PAT in full mode
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pmtp_reg <= tspfm_pkg::PMTP_RST;
        end else if (mode_f && pat_hit) begin
            pmtp_reg <= i_pkt.tbl_pid;
        end else if (i_wr && i_addr == tspfm_pkg::OFS_PMTP) begin
            pmtp_reg <= i_wdata[12:0];
        end
    end

    // filter table; hardware update wins over a host write
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int k = 0; k < NUM_FILT; k++) begin
                ent_reg[k] <= '0;
            end
        end else if (upd) begin
            ent_reg[upd_idx].valid <= 1'b1;
            ent_reg[upd_idx].stype <= i_pkt.tbl_type;
            ent_reg[upd_idx].pid   <= i_pkt.tbl_pid;
        end else if (i_wr && wr_ent) begin
            ent_reg[wr_idx] <= ent_wr;
        end
    end

    // table store to memory in mode A
    assign store_ev = mode_a && decode
                      && ((state_reg == tspfm_pkg::ST_PAT && pat_hit)
                          || (state_reg == tspfm_pkg::ST_PMT
                              && pmt_hit));

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            off_reg <= tspfm_pkg::WORD_RST;
        end else if (i_wr && i_addr == tspfm_pkg::OFS_BASE) begin
            off_reg <= tspfm_pkg::WORD_RST;
        end else if (store_ev) begin
            off_reg <= off_reg + tspfm_pkg::ADDR_INC;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_store_valid <= 1'b0;
            o_store       <= '0;
        end else begin
            o_store_valid <= store_ev;
            if (store_ev) begin
                o_store.addr <= base_reg + off_reg;
                o_store.data <= {8'h00, i_pkt.tbl_type,
                                 3'h0, i_pkt.tbl_pid};
            end
        end
    end

    // interrupt events
    always_comb begin
        ev                     = '0;
        ev[tspfm_pkg::IRQ_BND] = bnd_hit;
        ev[tspfm_pkg::IRQ_PAT] = mode_a && pat_hit;
        ev[tspfm_pkg::IRQ_PMT] = mode_a && pmt_hit
            && state_reg == tspfm_pkg::ST_PMT;
    end

    // write one clears, a new event in the same cycle wins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stat_reg <= '0;
        end else if (i_wr && i_addr == tspfm_pkg::OFS_STAT) begin
            stat_reg <= (stat_reg & ~i_wdata[tspfm_pkg::IRQ_W-1:0])
                        | ev;
        end else begin
            stat_reg <= stat_reg | ev;
        end
    end

    assign o_irq = |(stat_reg & mask_reg);

    // packet forwarding; bypass lets everything through
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pkt_valid <= 1'b0;
            o_pkt_pid   <= '0;
        end else begin
            o_pkt_valid <= i_pkt_valid
                           && (!act || |pid_hit);
            if (i_pkt_valid) begin
                o_pkt_pid <= i_pkt.pid;
            end
        end
    end

    // register read, data stand one cycle later
    always_comb begin
        rdata_next = '0;
        case (i_addr)
            tspfm_pkg::OFS_MAIN: rdata_next[0] = rsm_reg;
            tspfm_pkg::OFS_FILT:
                rdata_next[tspfm_pkg::FILT_W-1:0] = filt_reg;
            tspfm_pkg::OFS_STAT:
                rdata_next[tspfm_pkg::IRQ_W-1:0] = stat_reg;
            tspfm_pkg::OFS_MASK:
                rdata_next[tspfm_pkg::IRQ_W-1:0] = mask_reg;
            tspfm_pkg::OFS_BPID: rdata_next[12:0] = bpid_reg;
            tspfm_pkg::OFS_PMTP: rdata_next[12:0] = pmtp_reg;
            tspfm_pkg::OFS_BASE: rdata_next = base_reg;
            default: begin
                if (wr_ent) begin
                    rdata_next = ent_reg[wr_idx];
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= '0;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_pmt_a;
        state_reg == tspfm_pkg::ST_PMT && pmt_hit && mode_a;
    endsequence

    sequence s_bnd_a;
        state_reg == tspfm_pkg::ST_RUN && bnd_hit && mode_a;
    endsequence

    sequence s_back_pat;
        state_reg == tspfm_pkg::ST_PAT
        && stat_reg[tspfm_pkg::IRQ_BND];
    endsequence

    bypass_pass_a: assert property (
        (!act && i_pkt_valid) |=> o_pkt_valid)
        else $error("bypass dropped a packet");

    fen_gate_a: assert property (
        !rsm_reg |=> state_reg == tspfm_pkg::ST_IDLE
                     && !$rose(stat_reg[tspfm_pkg::IRQ_BND]))
        else $error("filter acted without stream mode");

    drop_miss_a: assert property (
        (act && i_pkt_valid && !(|pid_hit)) |=> !o_pkt_valid)
        else $error("unmatched packet forwarded");

    pat_irq_a: assert property (
        (mode_a && pat_hit) |=> stat_reg[tspfm_pkg::IRQ_PAT])
        else $error("new PAT raised no interrupt");

    pmt_store_a: assert property (
        s_pmt_a |=> o_store_valid
                    && stat_reg[tspfm_pkg::IRQ_PMT]
                    && state_reg == tspfm_pkg::ST_RUN)
        else $error("PMT not stored or signalled");

    bnd_return_a: assert property (
        s_bnd_a |=> s_back_pat)
        else $error("boundary did not return to PAT wait");

    manual_quiet_a: assert property (
        (filt_reg.mode == tspfm_pkg::MODE_MANUAL)
        [*2] |-> !o_store_valid && state_reg == tspfm_pkg::ST_IDLE)
        else $error("manual mode decoded a table");

    bsel_ignore_a: assert property (
        !filt_reg.fen |=> !$rose(stat_reg[tspfm_pkg::IRQ_BND]))
        else $error("boundary seen with filter off");

    mode_b_start_a: assert property (
        (decode && mode_b && state_reg == tspfm_pkg::ST_IDLE)
        |=> state_reg == tspfm_pkg::ST_RUN)
        else $error("mode B did not start parsing");

    type_replace_a: assert property (
        (upd && |type_hit) |=> ent_reg[$past(upd_idx)].pid
                               == $past(i_pkt.tbl_pid))
        else $error("same type entry not replaced");

    mask_keep_a: assert property (
        (i_wr && i_addr == tspfm_pkg::OFS_MASK)
        |=> filt_reg == $past(filt_reg))
        else $error("mask write disturbed filter control");

endmodule
`default_nettype wire

// ===== tspfm_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tspfm_top_tb;
    logic                    clk;
    logic                    reset;
    logic [7:0]              addr;
    logic [31:0]             wdata;
    logic                    wr;
    logic                    rd;
    logic [31:0]             rdata;
    logic                    pkt_valid;
    tspfm_pkg::tspfm_pkt_t   pkt;
    logic                    fwd_valid;
    logic [12:0]             fwd_pid;
    logic                    st_valid;
    tspfm_pkg::tspfm_store_t st;
    logic                    irq;
    logic                    go;
    logic [1:0]              dly;
    tspfm_pkg::tspfm_pkt_t   desc;
    logic [31:0]             last_data;
    logic [31:0]             last_addr;
    logic [31:0]             ent_w;
    int                      error_cnt;
    int                      tests_run;
    int                      n_store = 0;
    // bench model of the filter table and control
    int                      m_pid[6];
    int                      m_typ[6];
    int                      m_val[6];
    int                      m_pmtp;
    int                      m_mode;
    int                      m_act;
    int                      m_mask;
    int                      i;
    int                      ns;
    int                      old;

    tspfm_top i_tspfm_top (.i_clk(clk), .i_reset(reset), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_pkt_valid(pkt_valid), .i_pkt(pkt), .o_pkt_valid(fwd_valid),
        .o_pkt_pid(fwd_pid), .o_store_valid(st_valid), .o_store(st),
        .o_irq(irq));
    tspfm_src i_tspfm_src (.i_clk(clk), .i_reset(reset), .i_go(go),
        .i_delay(dly), .i_desc(desc), .o_valid(pkt_valid), .o_pkt(pkt));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (st_valid === 1'b1) begin
            n_store++;
            last_data = st.data;
            last_addr = st.addr;
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_word(rdata, exp);
    endtask

    // status read, then the interrupt level it implies, then clear
    task automatic st_chk(input logic [31:0] exp);
        rd_chk(tspfm_pkg::OFS_STAT, exp);
        chk_flag(irq, |(exp & m_mask));
        wr_reg(tspfm_pkg::OFS_STAT, exp);
    endtask

    task automatic cfg(input int main, input int filt);
        wr_reg(tspfm_pkg::OFS_MAIN, main);
        wr_reg(tspfm_pkg::OFS_FILT, filt);
        m_act  = main & (filt >> 3) & 1;
        m_mode = filt & 7;
        repeat (2) @(posedge clk);
    endtask

    function automatic void upd(input int tp, input int tt);
        int k;
        int f;
        f = -1;
        for (k = 5; k >= 0; k--)
            if (m_val[k] == 0) f = k;
        for (k = 0; k < 6; k++)
            if (m_val[k] != 0 && m_typ[k] == tt) f = k;
        if (f >= 0) begin
            m_val[f] = 1;
            m_pid[f] = tp;
            m_typ[f] = tt;
        end
    endfunction

    task automatic send(input int pid, input logic discontinuity_info_table, input int tp,
                        input int tt);
        int k;
        int hit;
        hit = (m_act == 0);
        for (k = 0; k < 6; k++)
            if (m_val[k] != 0 && m_pid[k] == pid) hit = 1;
        @(posedge clk);
        desc <= {13'(pid), discontinuity_info_table, 13'(tp), 8'(tt)};
        dly  <= 2'($urandom_range(0, 2));
        go   <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pkt_valid !== 1'b1 && k < 8);
        #1;
        chk_flag(fwd_valid, hit[0]);
        chk_word(32'(fwd_pid), 32'(pid[12:0]));
        // reserved codes act as manual, so only modes B and full update
        if (m_act != 0 && (m_mode == 2 || m_mode == 3) && pid == m_pmtp)
            upd(tp, tt);
        if (m_act != 0 && m_mode == 3 && pid == 0) m_pmtp = tp;
    endtask

    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        {addr, wdata, wr, rd, go, dly, desc} = '0;
        {error_cnt, tests_run, m_act, m_mode, m_mask} = '0;
        m_pmtp = 32'h00001FFF;
        reset = 1'b1;
        void'($urandom(32'hb24fdef5));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd_chk(tspfm_pkg::OFS_PMTP, 32'h00001FFF);
        wr_reg(8'hFC, 32'hFFFFFFFF);
        rd_chk(8'hFC, 32'h00000000);
        chk_flag(irq, 1'b0);
        for (i = 0; i < 8; i++) begin
            wr_reg(tspfm_pkg::OFS_FILT, 32'hFFFFFFF0 | i);
            rd_chk(tspfm_pkg::OFS_FILT, 32'h00000010 | i);
        end
        for (i = 0; i < 6; i++) begin
            m_pid[i] = $urandom_range(13'h200, 13'h1FFE);
            m_typ[i] = 8'h10 + i;
            m_val[i] = (i != 5);
            ent_w = {m_val[i][0], 7'h0, m_typ[i][7:0], 3'h0, m_pid[i][12:0]};
            wr_reg(tspfm_pkg::OFS_ENT0 + 8'(4 * i), ent_w);
            rd_chk(tspfm_pkg::OFS_ENT0 + 8'(4 * i), ent_w);
        end
        // bypass with stream mode off, then with filter off
        for (i = 0; i < 8; i++) begin
            if (i % 4 == 0) cfg(i == 0 ? 0 : 1, i == 0 ? 8'h08 : 8'h00);
            send($urandom_range(13'h200, 13'h1FFE), 1'b0, 0, 0);
        end
        cfg(1, 8'h08);
        for (i = 0; i < 7; i++)
            send(i < 6 ? m_pid[i] : 13'h1FFF, 1'b0, 0, 0);
        // manual and reserved codes never decode tables
        for (i = 3; i < 8; i++) begin
            cfg(1, 8'h08 | (i == 3 ? 0 : i));
            ns = n_store;
            send(0, 1'b0, 13'h100, 0);
            st_chk(0);
            chk_word(n_store, ns);
        end
        wr_reg(tspfm_pkg::OFS_BASE, 32'h00000100);
        cfg(1, 8'h09);
        m_mask = 5;
        wr_reg(tspfm_pkg::OFS_MASK, m_mask);
        rd_chk(tspfm_pkg::OFS_FILT, 32'h00000009);
        ns = n_store;
        send(0, 1'b0, 13'h100, 0);
        rd_chk(tspfm_pkg::OFS_STAT, 32'h00000002);
        chk_flag(irq, 1'b0);
        chk_word(n_store, ns + 1);
        chk_word(last_data, 32'h00000100);
        chk_word(last_addr, 32'h00000100);
        m_mask = 7;
        wr_reg(tspfm_pkg::OFS_MASK, m_mask);
        st_chk(2);
        rd_chk(tspfm_pkg::OFS_STAT, 32'h00000000);
        chk_flag(irq, 1'b0);
        wr_reg(tspfm_pkg::OFS_PMTP, 32'h00000100);
        send(13'h100, 1'b0, 13'h0E1, 8'h1B);
        st_chk(4);
        chk_word(n_store, ns + 2);
        chk_word(last_data, 32'h001B00E1);
        chk_word(last_addr, 32'h00000104);
        send($urandom_range(13'h200, 13'h1FFE), 1'b1, 0, 0);
        st_chk(1);
        send(0, 1'b0, 13'h100, 0);
        st_chk(2);
        // user packet as boundary marker, then select ignored when off
        wr_reg(tspfm_pkg::OFS_BPID, 32'h00000050);
        for (i = 0; i < 2; i++) begin
            cfg(1, i == 0 ? 8'h19 : 8'h11);
            send($urandom_range(13'h200, 13'h1FFE), 1'b1, 0, 0);
            st_chk(0);
            send(13'h050, 1'b0, 0, 0);
            st_chk(i == 0 ? 1 : 0);
        end
        wr_reg(tspfm_pkg::OFS_PMTP, 32'h000000C0);
        m_pmtp = 13'h0C0;
        cfg(1, 8'h0A);
        send(m_pid[0], 1'b0, 0, 0);
        old = m_pid[2];
        send(13'h0C0, 1'b0, 13'h0D2, 8'h12);
        send(old, 1'b0, 0, 0);
        send(13'h0D2, 1'b0, 0, 0);
        send(13'h0C0, 1'b0, 13'h0D7, 8'h1B);
        send(13'h0D7, 1'b0, 0, 0);
        // pass through manual so full mode starts from the idle state
        cfg(1, 8'h08);
        cfg(1, 8'h0B);
        send(0, 1'b0, 13'h0A5, 0);
        rd_chk(tspfm_pkg::OFS_PMTP, 32'h000000A5);
        send(13'h0A5, 1'b0, 13'h0E3, 8'h13);
        send(13'h0E3, 1'b0, 0, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
